// >>> core/fwg_guard.sv
// Purpose: Write latch and sector protection command logic of a serial flash.
// Assumes: SPI pins arrive asynchronously and are sampled on mclk.
// Notes:   Effects are applied only on the chip select rising edge.
// Function
// - Write-latch-set opcode sets flag at deselect.
// - Modify commands refused unless write latch set.
// - Short opcode leaves write latch unchanged.
// - Latch commands ignore trailing bytes.
// - Write-latch-clear opcode clears flag at deselect.
// - Write-latch-clear also ends sequential program.
// - One protect bit per sector, reset ones.
// - Protect bit one blocks program and erase.
// - Protect command sets addressed sector bit.
// - Unprotect command clears addressed sector bit.
// - Protect or unprotect then clears write latch.
// - Short address aborts, clears write latch.
// - Bytes after address are ignored.
// - Lock flag blocks protect, clears latch.
// - Program to protected sector refused, latch cleared.
// - Chip erase refused if any sector protected.
// - Block erase in protected sector refused.
`timescale 1ns/1ps
`default_nettype none
module fwg_guard
  import fwg_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       cs_n,
  input  wire logic                       sck,
  input  wire logic                       mosi,
  input  wire logic                       protection_regs_lock,
  input  wire logic                       seq_prog_active,
  output var  logic                       write_latch_flag,
  output var  logic [FWG_NUM_SECTORS-1:0] sector_prot,
  output var  logic                       seq_prog_exit,
  output var  fwg_op_s                    op_req,
  output var  logic                       op_valid
);

  logic [1:0]  cs_sync_q;
  logic [1:0]  sck_sync_q;
  logic [1:0]  mosi_sync_q;
  logic        cs_q;
  logic        sck_q;
  logic [5:0]  bits_q;
  logic [7:0]  opcode_q;
  logic [23:0] addr_q;
  fwg_state_e  state_q;
  logic        cs_rise;
  logic        cs_fall;
  logic        sck_rise;
  logic        frame_end;
  logic        op_done;
  logic        addr_done;
  logic        data_done;
  logic        sect_prot;
  logic        latch_cmd;
  logic        sect_cmd;

  // Two-flop synchronisers; only the second stage is read by logic.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_sync_q   <= 2'h3;
      sck_sync_q  <= 2'h0;
      mosi_sync_q <= 2'h0;
      cs_q        <= 1'b1;
      sck_q       <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      sck_sync_q  <= {sck_sync_q[0], sck};
      mosi_sync_q <= {mosi_sync_q[0], mosi};
      cs_q        <= cs_sync_q[1];
      sck_q       <= sck_sync_q[1];
    end
  end

  assign cs_fall  = cs_q && !cs_sync_q[1];
  assign cs_rise  = !cs_q && cs_sync_q[1];
  assign sck_rise = !sck_q && sck_sync_q[1] && !cs_sync_q[1];

  // Frame sequencer: counting while selected, one evaluation cycle after.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= FWG_CMD_IDLE;
    end else begin
      case (state_q)
        FWG_CMD_IDLE: if (cs_fall) state_q <= FWG_CMD_RECV;
        FWG_CMD_RECV: if (cs_rise) state_q <= FWG_CMD_EXEC;
        FWG_CMD_EXEC: state_q <= FWG_CMD_DONE;
        FWG_CMD_DONE: state_q <= FWG_CMD_IDLE;
        default:      state_q <= FWG_CMD_IDLE;
      endcase
    end
  end

  assign frame_end = (state_q == FWG_CMD_EXEC);

  // Bit counter saturates past the first data byte so long frames are harmless.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bits_q <= 6'h00;
    end else if (cs_fall) begin
      bits_q <= 6'h00;
    end else if (sck_rise && bits_q != FWG_BITS_DATA_END) begin
      bits_q <= bits_q + 6'h01;
    end
  end

  // Opcode and address shifters; later bytes are never captured.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opcode_q <= 8'h00;
      addr_q   <= 24'h000000;
    end else if (sck_rise && state_q == FWG_CMD_RECV) begin
      if (bits_q < FWG_BITS_OPCODE) begin
        opcode_q <= {opcode_q[6:0], mosi_sync_q[1]};
      end else if (bits_q < FWG_BITS_ADDR_END) begin
        addr_q <= {addr_q[22:0], mosi_sync_q[1]};
      end
    end
  end

  assign op_done   = (bits_q >= FWG_BITS_OPCODE);
  assign addr_done = (bits_q >= FWG_BITS_ADDR_END);
  assign data_done = (bits_q >= FWG_BITS_DATA_END);
  assign sect_prot = sector_prot[addr_q[FWG_SECT_LSB +: FWG_SECT_W]];
  assign latch_cmd = op_done && (opcode_q == FWG_OP_WR_EN || opcode_q == FWG_OP_WR_DIS);
  assign sect_cmd  = op_done && (opcode_q == FWG_OP_PROTECT || opcode_q == FWG_OP_UNPROTECT);

  // Write latch: set, clear, and the many ways a modify command drops it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      write_latch_flag <= FWG_WLF_RST;
    end else if (frame_end && op_done) begin
      case (opcode_q)
        FWG_OP_WR_EN:  write_latch_flag <= 1'b1;
        FWG_OP_WR_DIS: write_latch_flag <= 1'b0;
        FWG_OP_PROTECT, FWG_OP_UNPROTECT:
          write_latch_flag <= 1'b0;
        FWG_OP_PROG_BYTE: if (!data_done || sect_prot) write_latch_flag <= 1'b0;
        FWG_OP_ERASE_4K, FWG_OP_ERASE_32K, FWG_OP_ERASE_64K:
          if (!addr_done || sect_prot) write_latch_flag <= 1'b0;
        FWG_OP_CHIP_ER_A, FWG_OP_CHIP_ER_B:
          if (|sector_prot) write_latch_flag <= 1'b0;
        default: write_latch_flag <= write_latch_flag;
      endcase
    end
  end

  // Sector protection bits; all set at reset, a lock freezes them.
  genvar s;
  generate
    for (s = 0; s < FWG_NUM_SECTORS; s = s + 1) begin : g_sect
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          sector_prot[s] <= FWG_PROT_RST[s];
        end else if (frame_end && sect_cmd && addr_done && write_latch_flag
                     && !protection_regs_lock
                     && addr_q[FWG_SECT_LSB +: FWG_SECT_W] == FWG_SECT_W'(s)) begin
          sector_prot[s] <= (opcode_q == FWG_OP_PROTECT);
        end
      end
    end
  endgenerate

  // Allowed array operations leave as a one-cycle request to the array engine.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op_req        <= '0;
      op_valid      <= 1'b0;
      seq_prog_exit <= 1'b0;
    end else begin
      op_valid      <= 1'b0;
      seq_prog_exit <= frame_end && latch_cmd && opcode_q == FWG_OP_WR_DIS
                       && seq_prog_active;
      if (frame_end && write_latch_flag) begin
        op_req.addr        <= addr_q;
        op_req.prog        <= (opcode_q == FWG_OP_PROG_BYTE);
        op_req.block_erase <= (opcode_q == FWG_OP_ERASE_4K || opcode_q == FWG_OP_ERASE_32K
                               || opcode_q == FWG_OP_ERASE_64K);
        op_req.chip_erase  <= (opcode_q == FWG_OP_CHIP_ER_A || opcode_q == FWG_OP_CHIP_ER_B);
        op_req.wr_status   <= (opcode_q == FWG_OP_WR_STATUS);
        if (opcode_q == FWG_OP_PROG_BYTE) op_valid <= data_done && !sect_prot;
        else if (opcode_q == FWG_OP_ERASE_4K || opcode_q == FWG_OP_ERASE_32K
                 || opcode_q == FWG_OP_ERASE_64K) op_valid <= addr_done && !sect_prot;
        else if (opcode_q == FWG_OP_CHIP_ER_A || opcode_q == FWG_OP_CHIP_ER_B)
          op_valid <= op_done && !(|sector_prot);
        else if (opcode_q == FWG_OP_WR_STATUS) op_valid <= data_done;
      end
    end
  end

  // Helper: opcode as seen at the evaluation cycle.
  logic [7:0] op_at_end;
  assign op_at_end = opcode_q;

  property p_wen_sets;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && op_done && op_at_end == FWG_OP_WR_EN |=> write_latch_flag;
  endproperty
  a_wen_sets: assert property (p_wen_sets) else $error("Write enable did not set latch.");

  property p_wdis_clears;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && op_done && op_at_end == FWG_OP_WR_DIS |=> !write_latch_flag;
  endproperty
  a_wdis_clears: assert property (p_wdis_clears) else $error("Write disable kept latch.");

  property p_short_opcode;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && !op_done |=> $stable(write_latch_flag) && $stable(sector_prot);
  endproperty
  a_short_opcode: assert property (p_short_opcode) else $error("Short opcode changed state.");

  property p_sect_clears_wlf;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && sect_cmd |=> !write_latch_flag;
  endproperty
  a_sect_clears_wlf: assert property (p_sect_clears_wlf) else $error("Latch kept after sector op.");

  property p_short_addr;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && sect_cmd && !addr_done |=> $stable(sector_prot);
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("Short address changed protection.");

  property p_lock_blocks;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && protection_regs_lock |=> $stable(sector_prot);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("Locked protection changed.");

  property p_need_wlf;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && !write_latch_flag |=> !op_valid && $stable(sector_prot);
  endproperty
  a_need_wlf: assert property (p_need_wlf) else $error("Command ran without latch.");

  sequence s_frame_close;
    cs_rise ##1 frame_end;
  endsequence
  property p_prot_sets;
    @(posedge mclk) disable iff (!rst_n)
      s_frame_close ##0 (sect_cmd && addr_done && write_latch_flag && !protection_regs_lock
                         && opcode_q == FWG_OP_PROTECT) |=> sect_prot;
  endproperty
  a_prot_sets: assert property (p_prot_sets) else $error("Protect did not set bit.");

  property p_chip_blocked;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && (opcode_q == FWG_OP_CHIP_ER_A) && (|sector_prot) |=> !op_valid;
  endproperty
  a_chip_blocked: assert property (p_chip_blocked) else $error("Chip erase passed protection.");

  // Unprotect mirrors protect; the addressed bit must fall the cycle after evaluation.
  property p_unprot_clears;
    @(posedge mclk) disable iff (!rst_n)
      s_frame_close ##0 (sect_cmd && addr_done && write_latch_flag && !protection_regs_lock
                         && opcode_q == FWG_OP_UNPROTECT) |=> !sect_prot;
  endproperty
  a_unprot_clears: assert property (p_unprot_clears) else $error("Unprotect kept bit.");

  property p_seq_exit;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && latch_cmd && opcode_q == FWG_OP_WR_DIS && seq_prog_active |=> seq_prog_exit;
  endproperty
  a_seq_exit: assert property (p_seq_exit) else $error("Write disable kept sequential mode.");

  // Pulses may only follow an evaluation cycle, never a bit arriving mid-frame.
  property p_pulse_at_end;
    @(posedge mclk) disable iff (!rst_n)
      !frame_end |=> !op_valid && !seq_prog_exit;
  endproperty
  a_pulse_at_end: assert property (p_pulse_at_end) else $error("Pulse outside deselect.");

  property p_count_restart;
    @(posedge mclk) disable iff (!rst_n)
      cs_fall |=> bits_q == 6'h00;
  endproperty
  a_count_restart: assert property (p_count_restart) else $error("Bit count not restarted.");

  property p_prog_blocked;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && op_done && opcode_q == FWG_OP_PROG_BYTE && sect_prot
      |=> !op_valid && !write_latch_flag;
  endproperty
  a_prog_blocked: assert property (p_prog_blocked) else $error("Program hit protected sector.");

  property p_prog_goes;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && write_latch_flag && opcode_q == FWG_OP_PROG_BYTE && data_done && !sect_prot
      |=> op_valid && op_req.prog;
  endproperty
  a_prog_goes: assert property (p_prog_goes) else $error("Allowed program not issued.");

  property p_blk_blocked;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && op_done && opcode_q == FWG_OP_ERASE_64K && sect_prot
      |=> !op_valid && !write_latch_flag;
  endproperty
  a_blk_blocked: assert property (p_blk_blocked) else $error("Erase hit protected sector.");

  property p_blk_goes;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && write_latch_flag && opcode_q == FWG_OP_ERASE_64K && addr_done && !sect_prot
      |=> op_valid && op_req.block_erase;
  endproperty
  a_blk_goes: assert property (p_blk_goes) else $error("Allowed erase not issued.");

  property p_chip_clears;
    @(posedge mclk) disable iff (!rst_n)
      frame_end && op_done && (opcode_q == FWG_OP_CHIP_ER_A || opcode_q == FWG_OP_CHIP_ER_B)
      && (|sector_prot) |=> !write_latch_flag;
  endproperty
  a_chip_clears: assert property (p_chip_clears) else $error("Refused chip erase kept latch.");

endmodule : fwg_guard
`default_nettype wire

// >>> inc/fwg_pkg.sv
// Purpose: Shared constants and types for the flash write guard block.
// Assumes: SPI mode 0 or 3, MSB first, 24-bit addresses, 64 KB sectors.
// Notes:   Opcodes, sector count and reset values live here only.
package fwg_pkg;

  localparam logic [7:0] FWG_OP_WR_EN      = 8'h06;
  localparam logic [7:0] FWG_OP_WR_DIS     = 8'h04;
  localparam logic [7:0] FWG_OP_PROTECT    = 8'h36;
  localparam logic [7:0] FWG_OP_UNPROTECT  = 8'h39;
  localparam logic [7:0] FWG_OP_PROG_BYTE  = 8'h02;
  localparam logic [7:0] FWG_OP_ERASE_4K   = 8'h20;
  localparam logic [7:0] FWG_OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] FWG_OP_ERASE_64K  = 8'hD8;
  localparam logic [7:0] FWG_OP_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] FWG_OP_CHIP_ER_B  = 8'hC7;
  localparam logic [7:0] FWG_OP_WR_STATUS  = 8'h01;

  localparam int         FWG_NUM_SECTORS   = 64;
  localparam int         FWG_SECT_LSB      = 16;
  localparam int         FWG_SECT_W        = 6;
  localparam logic [FWG_NUM_SECTORS-1:0] FWG_PROT_RST = {FWG_NUM_SECTORS{1'b1}};
  localparam logic       FWG_WLF_RST       = 1'b0;
  localparam logic [5:0] FWG_BITS_OPCODE   = 6'h08;
  localparam logic [5:0] FWG_BITS_ADDR_END = 6'h20;
  localparam logic [5:0] FWG_BITS_DATA_END = 6'h28;

  typedef enum logic [3:0] {
    FWG_CMD_IDLE = 4'b0001,
    FWG_CMD_RECV = 4'b0010,
    FWG_CMD_EXEC = 4'b0100,
    FWG_CMD_DONE = 4'b1000
  } fwg_state_e;

  // Request handed to the array engine when a program, erase or status write is allowed.
  typedef struct packed {
    logic        prog;
    logic        block_erase;
    logic        chip_erase;
    logic        wr_status;
    logic [23:0] addr;
  } fwg_op_s;

endpackage : fwg_pkg

// >>> sim/fwg_host.sv
// Purpose: SPI host model that frames commands for the guard.
// Assumes: Mode 0, MSB first, sck period of 8 mclk.
// Notes:   Mosi toggles between frames so stale bits never look valid.
`timescale 1ns/1ps
`default_nettype none
module fwg_host (
  input  wire logic mclk,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic mosi
);
  logic idle = 1'b1;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // Outside a frame the data line keeps changing, so the guard must ignore it.
  always @(posedge mclk) if (idle) mosi <= ~mosi;
  // Sends the top n bits of d: opcode, then address MSB first.
  task automatic frame(input logic [39:0] d, input int n);
    @(posedge mclk);
    idle <= 1'b0;
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      mosi <= d[39-i];
      repeat (3) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    idle <= 1'b1;
  endtask : frame
endmodule : fwg_host
`default_nettype wire

// >>> sim/fwg_guard_tb_top.sv
// Purpose: Self-checking bench for the flash write guard.
// Assumes: Effects land 4 mclk after deselect; bench waits 10.
// Notes:   Pulses are counted so a stuck or missing pulse is seen.
`timescale 1ns/1ps
`default_nettype none
module fwg_guard_tb_top
  import fwg_pkg::*;
;
  logic                       mclk, rst_n, cs_n, sck, mosi, lock, seq;
  logic                       wlf, ex, opv;
  logic [FWG_NUM_SECTORS-1:0] prot;
  fwg_op_s                    op, op_seen;
  int                         num_errors = 0, num_checks = 0, n_ex = 0, n_op = 0;
  localparam logic [63:0]     ALL = {64{1'b1}};
  localparam logic [63:0]     U5 = ALL ^ 64'h20;

  // Clock at 40 MHz.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  fwg_guard uut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .protection_regs_lock(lock), .seq_prog_active(seq), .write_latch_flag(wlf),
    .sector_prot(prot), .seq_prog_exit(ex), .op_req(op), .op_valid(opv));
  fwg_host host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .mosi(mosi));

  // Count one-cycle pulses and keep the last request that was let through.
  always @(posedge mclk) begin
    if (ex === 1'b1) n_ex++;
    if (opv === 1'b1) begin
      n_op++;
      op_seen = op;
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One frame, then enough idle time for the effect to land.
  task automatic cmd(input logic [39:0] d, input int n);
    host.frame(d, n);
    repeat (10) @(posedge mclk);
  endtask : cmd

  task automatic wen;
    cmd({8'h06, 32'h0}, 8);
  endtask : wen

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // A hang ends the run as a failure instead of running forever.
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    lock = 1'b0;
    seq = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("latch", 1'b0, wlf);
    chk("prot", ALL, prot);
    $display("test reset done");
    cmd({8'h39, 24'h050000, 8'h0}, 32);
    chk("prot", ALL, prot);
    cmd({8'h06, 32'h0}, 7);
    chk("latch", 1'b0, wlf);
    cmd({8'h06, 8'hA5, 24'h0}, 16);
    chk("latch", 1'b1, wlf);
    cmd({8'h04, 32'h0}, 7);
    chk("latch", 1'b1, wlf);
    seq <= 1'b1;
    cmd({8'h04, 8'hFF, 24'h0}, 16);
    chk("latch", 1'b0, wlf);
    chk("exit", 64'h1, n_ex);
    seq <= 1'b0;
    $display("test latch done");
    wen();
    cmd({8'h39, 24'h05ABCD, 8'h5A}, 40);
    chk("prot", U5, prot);
    chk("latch", 1'b0, wlf);
    wen();
    cmd({8'h02, 24'h030010, 8'h77}, 40);
    chk("ops", 64'h0, n_op);
    chk("latch", 1'b0, wlf);
    wen();
    cmd({8'h02, 24'h05FF00, 8'h77}, 40);
    chk("ops", 64'h1, n_op);
    chk("op", {1'b1, 3'h0, 24'h05FF00}, op_seen);
    wen();
    cmd({8'hD8, 24'h090000, 8'h0}, 32);
    chk("ops", 64'h1, n_op);
    chk("latch", 1'b0, wlf);
    wen();
    cmd({8'hD8, 24'h051234, 8'h0}, 32);
    chk("ops", 64'h2, n_op);
    chk("op", {1'b0, 1'b1, 2'h0, 24'h051234}, op_seen);
    wen();
    cmd({8'h60, 32'h0}, 8);
    chk("ops", 64'h2, n_op);
    chk("latch", 1'b0, wlf);
    $display("test guard done");
    cmd({8'h39, 24'h050000, 8'h0}, 20);
    chk("prot", U5, prot);
    wen();
    cmd({8'h36, 24'h05FFFF, 8'h0}, 32);
    chk("prot", ALL, prot);
    chk("latch", 1'b0, wlf);
    wen();
    cmd({8'h39, 24'h050000, 8'h0}, 20);
    chk("prot", ALL, prot);
    chk("latch", 1'b0, wlf);
    lock <= 1'b1;
    wen();
    cmd({8'h39, 24'h070000, 8'h0}, 32);
    chk("prot", ALL, prot);
    chk("latch", 1'b0, wlf);
    lock <= 1'b0;
    $display("test sector done");
    end_of_test();
  end
endmodule : fwg_guard_tb_top
`default_nettype wire
